// ---- l3_bus_event_counters.sv ----
/*
 * Bank of eight 64-bit event monitoring registers for L3 and system bus logic:
 * six qualified 32-bit event counters, a latency control word and a 64-bit
 * latency accumulator, reached by model-register read/write and counter-read.
 * Assumes requests are one-cycle pulses synchronous to mclk and that event
 * condition vectors are presented by the queue logic every cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module l3_bus_event_counters
   import l3_event_pkg::*;
#(
   parameter int NUM_EVENT_CTR = 6,
   parameter int LAT_STEP_W = 8
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic msr_rd_req,
   input wire logic msr_wr_req,
   input wire logic [31:0] msr_addr,
   input wire logic [63:0] msr_wdata,
   output logic [63:0] msr_rdata_reg,
   output logic msr_ack_reg,
   output logic msr_fault_reg,
   input wire logic pmc_rd_req,
   input wire logic [7:0] pmc_index,
   output logic [31:0] pmc_rdata_lo_reg,
   output logic [31:0] pmc_rdata_hi_reg,
   output logic pmc_ack_reg,
   output logic pmc_fault_reg,
   input wire logic [NUM_EVENT_CTR*CTL_W-1:0] event_cond,
   input wire logic [LAT_STEP_W-1:0] latency_weight
);

   // ==========================================================
   // Decode helpers
   function automatic logic msr_mapped(input logic [31:0] a);
      msr_mapped = (a >= ADDR_INBOUND_BUS_QUEUE_EVENT0) && (a <= ADDR_QUEUE_LATENCY_ACCUMULATOR);
   endfunction

   function automatic logic [2:0] msr_slot(input logic [31:0] a);
      logic [31:0] d;
      d = a - ADDR_INBOUND_BUS_QUEUE_EVENT0;
      msr_slot = d[2:0];
   endfunction

   function automatic logic pmc_mapped(input logic [7:0] i);
      pmc_mapped = (i >= PMC_INDEX_FIRST) && (i <= PMC_INDEX_LAST);
   endfunction

   function automatic logic [2:0] pmc_slot(input logic [7:0] i);
      logic [7:0] d;
      d = i - PMC_INDEX_FIRST;
      pmc_slot = d[2:0];
   endfunction

   // ==========================================================
   // Storage
   logic [CTL_W-1:0] ctl_reg [0:NUM_EVENT_CTR-1];
   logic [63:0] latency_ctl_reg;
   logic [COUNT_W-1:0] cnt [0:NUM_EVENT_CTR-1];
   logic [ACC_W-1:0] lat_acc;
   logic [NUM_EVENT_CTR-1:0] ctr_load;
   logic [NUM_EVENT_CTR-1:0] ctr_inc;
   logic wr_hit;
   logic [2:0] wr_slot;
   logic lat_en;
   logic lat_load;

   assign wr_hit = msr_wr_req && msr_mapped(msr_addr);
   assign wr_slot = msr_slot(msr_addr);

   // ==========================================================
   // Event counters
   genvar g;
   generate
      for (g = 0; g < NUM_EVENT_CTR; g = g + 1) begin : g_ctr
         // control half written with the counter half
         // snoop queue pair at slots 2 and 3
         // bus ready pair at slots 4 and 5
         assign ctr_load[g] = wr_hit && (wr_slot == 3'(g));
         // idle while control half is zero
         // qualification bits gate each of the six counters
         assign ctr_inc[g] = (ctl_reg[g] != CTL_RESET) && |(ctl_reg[g] & event_cond[g*CTL_W +: CTL_W]);

         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               ctl_reg[g] <= CTL_RESET;
            end else if (ctr_load[g]) begin
               ctl_reg[g] <= msr_wdata[CTL_LSB +: CTL_W];
            end
         end

         event_accumulator #(
            .WIDTH(COUNT_W),
            .STEP_W(1)
         ) u_ctr (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .load(ctr_load[g]),
            .load_value(msr_wdata[COUNT_W-1:0]),
            .inc(ctr_inc[g]),
            .step(1'b1),
            .count_reg(cnt[g])
         );
      end
   endgenerate

   // ==========================================================
   // Latency measurement
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         latency_ctl_reg <= LATENCY_CONTROL_RESET;
      end else if (wr_hit && (wr_slot == SLOT_LATENCY_CONTROL)) begin
         latency_ctl_reg <= msr_wdata;
      end
   end

   assign lat_en = latency_ctl_reg[LATENCY_ENABLE_BIT];
   assign lat_load = wr_hit && (wr_slot == SLOT_LATENCY_ACCUMULATOR);

   event_accumulator #(
      .WIDTH(ACC_W),
      .STEP_W(LAT_STEP_W)
   ) u_lat_acc (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .load(lat_load),
      .load_value(msr_wdata),
      .inc(lat_en),
      .step(latency_weight),
      .count_reg(lat_acc)
   );

   // ==========================================================
   // Model-register read and write answer
   // Reads see the value before this cycle's increment
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         msr_rdata_reg <= MSR_RDATA_RESET;
      end else if (msr_rd_req && msr_mapped(msr_addr)) begin
         case (msr_slot(msr_addr))
            SLOT_LATENCY_CONTROL: begin
               msr_rdata_reg <= latency_ctl_reg;
            end
            SLOT_LATENCY_ACCUMULATOR: begin
               msr_rdata_reg <= lat_acc;
            end
            default: begin
               msr_rdata_reg <= {ctl_reg[msr_slot(msr_addr)], cnt[msr_slot(msr_addr)]};
            end
         endcase
      end else if (msr_rd_req) begin
         msr_rdata_reg <= MSR_RDATA_RESET;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         msr_ack_reg <= 1'b0;
         msr_fault_reg <= 1'b0;
      end else begin
         msr_ack_reg <= msr_rd_req || msr_wr_req;
         msr_fault_reg <= (msr_rd_req || msr_wr_req) && !msr_mapped(msr_addr);
      end
   end

   // ==========================================================
   // Counter-read answer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pmc_rdata_lo_reg <= CTL_RESET;
      end else if (pmc_rd_req && pmc_mapped(pmc_index)) begin
         case (pmc_slot(pmc_index))
            SLOT_LATENCY_CONTROL: begin
               pmc_rdata_lo_reg <= latency_ctl_reg[COUNT_W-1:0];
            end
            SLOT_LATENCY_ACCUMULATOR: begin
               pmc_rdata_lo_reg <= lat_acc[COUNT_W-1:0];
            end
            default: begin
               pmc_rdata_lo_reg <= cnt[pmc_slot(pmc_index)];
            end
         endcase
      end else if (pmc_rd_req) begin
         pmc_rdata_lo_reg <= CTL_RESET;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pmc_rdata_hi_reg <= UPPER_RESULT_ZERO;
         pmc_ack_reg <= 1'b0;
         pmc_fault_reg <= 1'b0;
      end else begin
         pmc_rdata_hi_reg <= UPPER_RESULT_ZERO;
         pmc_ack_reg <= pmc_rd_req;
         pmc_fault_reg <= pmc_rd_req && !pmc_mapped(pmc_index);
      end
   end

   // ==========================================================
   // Checks
   sequence s_no_write;
      !msr_wr_req;
   endsequence

   sequence s_pmc_first;
      pmc_rd_req && (pmc_index == PMC_INDEX_FIRST) && !msr_wr_req;
   endsequence

   sequence s_lat_running;
      lat_en && !msr_wr_req;
   endsequence

   AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
      pmc_ack_reg |-> (pmc_rdata_hi_reg == UPPER_RESULT_ZERO))
      else $error("Counter-read upper half not zero");

   AST_PMC_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
      pmc_rd_req |=> pmc_ack_reg && (pmc_fault_reg == !pmc_mapped($past(pmc_index))))
      else $error("Counter-read index decode wrong");

   AST_PMC_FIRST: assert property (@(posedge mclk) disable iff (sys_rst)
      s_pmc_first |=> (pmc_rdata_lo_reg == $past(cnt[0])))
      else $error("Index 18 does not return first counter");

   AST_MSR_FAULT: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_rd_req && !msr_mapped(msr_addr)) |=> msr_ack_reg && msr_fault_reg)
      else $error("Unmapped access not refused");

   AST_MSR_READBACK: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_wr_req && (msr_addr == ADDR_INBOUND_SNOOP_QUEUE_EVENT0) && (msr_wdata[CTL_LSB +: CTL_W] == CTL_RESET))
      ##1 s_no_write ##1 (msr_rd_req && (msr_addr == ADDR_INBOUND_SNOOP_QUEUE_EVENT0) && !msr_wr_req)
      |=> (msr_rdata_reg == $past(msr_wdata, 3)))
      else $error("Register does not read back as written");

   AST_IDLE_BUSQ: assert property (@(posedge mclk) disable iff (sys_rst)
      ((ctl_reg[0] == CTL_RESET) and s_no_write) |=> $stable(cnt[0]))
      else $error("Unarmed queue counter moved");

   AST_IDLE_READY: assert property (@(posedge mclk) disable iff (sys_rst)
      ((ctl_reg[4] == CTL_RESET) and s_no_write) ##1 s_no_write |=> (cnt[4] == $past(cnt[4], 2)))
      else $error("Unarmed bus ready counter moved");

   AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (sys_rst)
      (|(ctl_reg[2] & event_cond[2*CTL_W +: CTL_W]) && !msr_wr_req) |=> (cnt[2] == $past(cnt[2]) + 32'h0000_0001))
      else $error("Qualified event did not add one");

   AST_COUNT_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
      (ctr_inc[5] && (cnt[5] == 32'hFFFF_FFFF) && !msr_wr_req) |=> (cnt[5] == 32'h0000_0000))
      else $error("Counter did not wrap to zero");

   AST_LAT_ACC: assert property (@(posedge mclk) disable iff (sys_rst)
      s_lat_running |=> (lat_acc == $past(lat_acc) + 64'($past(latency_weight))))
      else $error("Latency accumulator missed weight");

   AST_LAT_FREEZE: assert property (@(posedge mclk) disable iff (sys_rst)
      (!lat_en && !msr_wr_req) [*2] |=> $stable(lat_acc))
      else $error("Latency accumulator moved while frozen");

   // Any carry out of the low word, not only from all ones
   AST_LAT_WIDE: assert property (@(posedge mclk) disable iff (sys_rst)
      (lat_en && !msr_wr_req && (lat_acc[31:0] > (32'hFFFF_FFFF - 32'(latency_weight))))
      |=> (lat_acc[63:32] == $past(lat_acc[63:32]) + 32'h0000_0001))
      else $error("Accumulator carry into upper half lost");

   // ==========================================================
   // Checks on answers, write landing, refusal, idle counting and counter-read
   sequence s_acc_write;
      msr_wr_req && (msr_addr == ADDR_QUEUE_LATENCY_ACCUMULATOR);
   endsequence

   AST_MSR_ACK: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_rd_req || msr_wr_req) |=> msr_ack_reg)
      else $error("Register access not answered");

   AST_MSR_QUIET: assert property (@(posedge mclk) disable iff (sys_rst)
      (!msr_rd_req && !msr_wr_req) |=> (!msr_ack_reg && !msr_fault_reg))
      else $error("Register answer without request");

   AST_WRITE_FAULT: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_wr_req && !msr_mapped(msr_addr)) |=> (msr_ack_reg && msr_fault_reg))
      else $error("Unmapped write not refused");

   AST_UNMAPPED_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_rd_req && !msr_mapped(msr_addr)) |=> (msr_rdata_reg == MSR_RDATA_RESET))
      else $error("Unmapped read data not zero");

   AST_BUSQ_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_wr_req && (msr_addr == ADDR_INBOUND_BUS_QUEUE_EVENT0)) |=> ({ctl_reg[0], cnt[0]} == $past(msr_wdata)))
      else $error("Bus queue register write did not land");

   AST_SNOOP_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_wr_req && (msr_addr == ADDR_INBOUND_SNOOP_QUEUE_EVENT1)) |=> ({ctl_reg[3], cnt[3]} == $past(msr_wdata)))
      else $error("Snoop queue register write did not land");

   AST_READY_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_wr_req && (msr_addr == ADDR_EXTERNAL_BUS_READY_EVENT1)) |=> ({ctl_reg[5], cnt[5]} == $past(msr_wdata)))
      else $error("Bus ready register write did not land");

   AST_IDLE_SNOOP: assert property (@(posedge mclk) disable iff (sys_rst)
      ((ctl_reg[3] == CTL_RESET) and s_no_write) |=> $stable(cnt[3]))
      else $error("Unarmed snoop counter moved");

   AST_LAT_CTL_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
      (msr_wr_req && (msr_addr == ADDR_QUEUE_LATENCY_CONTROL)) |=> (latency_ctl_reg == $past(msr_wdata)))
      else $error("Latency control write did not land");

   AST_LAT_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
      s_acc_write |=> (lat_acc == $past(msr_wdata)))
      else $error("Accumulator write did not land");

   AST_PMC_LAST: assert property (@(posedge mclk) disable iff (sys_rst)
      (pmc_rd_req && (pmc_index == PMC_INDEX_LAST)) |=> (pmc_rdata_lo_reg == $past(lat_acc[31:0])))
      else $error("Index 25 does not return accumulator low half");

   AST_PMC_REFUSED: assert property (@(posedge mclk) disable iff (sys_rst)
      (pmc_rd_req && !pmc_mapped(pmc_index)) |=> (pmc_rdata_lo_reg == 32'h0000_0000))
      else $error("Refused counter-read data not zero");

   AST_PMC_QUIET: assert property (@(posedge mclk) disable iff (sys_rst)
      !pmc_rd_req |=> (!pmc_ack_reg && !pmc_fault_reg))
      else $error("Counter-read answer without request");

endmodule

`default_nettype wire

// ---- l3_event_pkg.sv ----
/*
 * Constants shared by the L3 and bus event counter bank: register addresses,
 * field positions, counter-read indices and reset values.
 * Assumes a single clock domain and 64-bit model-register accesses.
 */
package l3_event_pkg;

   // ==========================================================
   // Register addresses
   localparam logic [31:0] ADDR_INBOUND_BUS_QUEUE_EVENT0 = 32'h0001_07CC;
   localparam logic [31:0] ADDR_INBOUND_BUS_QUEUE_EVENT1 = 32'h0001_07CD;
   localparam logic [31:0] ADDR_INBOUND_SNOOP_QUEUE_EVENT0 = 32'h0001_07CE;
   localparam logic [31:0] ADDR_INBOUND_SNOOP_QUEUE_EVENT1 = 32'h0001_07CF;
   localparam logic [31:0] ADDR_EXTERNAL_BUS_READY_EVENT0 = 32'h0001_07D0;
   localparam logic [31:0] ADDR_EXTERNAL_BUS_READY_EVENT1 = 32'h0001_07D1;
   localparam logic [31:0] ADDR_QUEUE_LATENCY_CONTROL = 32'h0001_07D2;
   localparam logic [31:0] ADDR_QUEUE_LATENCY_ACCUMULATOR = 32'h0001_07D3;

   // ==========================================================
   // Slot numbering inside the bank
   localparam logic [2:0] SLOT_LATENCY_CONTROL = 3'h6;
   localparam logic [2:0] SLOT_LATENCY_ACCUMULATOR = 3'h7;

   // ==========================================================
   // Counter-read instruction indices
   localparam logic [7:0] PMC_INDEX_FIRST = 8'h12;
   localparam logic [7:0] PMC_INDEX_LAST = 8'h19;

   // ==========================================================
   // Field layout
   localparam int CTL_LSB = 32;
   localparam int CTL_W = 32;
   localparam int COUNT_W = 32;
   localparam int ACC_W = 64;
   localparam int LATENCY_ENABLE_BIT = 26;

   // ==========================================================
   // Reset values
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [63:0] LATENCY_CONTROL_RESET = 64'h0000_0000_0000_0000;
   localparam logic [63:0] MSR_RDATA_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] UPPER_RESULT_ZERO = 32'h0000_0000;

endpackage

// ---- event_accumulator.sv ----
/*
 * Wrapping accumulator: adds a step each cycle it is enabled, software load wins.
 * Assumes the step is zero-extended and the load value is presented with load.
 */
`timescale 1ns/10ps
`default_nettype none

module event_accumulator #(
   parameter int WIDTH = 32,
   parameter int STEP_W = 1
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic inc,
   input wire logic [STEP_W-1:0] step,
   output logic [WIDTH-1:0] count_reg
);

   logic [WIDTH-1:0] count_next;

   // ==========================================================
   // Next value
   always_comb begin
      count_next = count_reg + WIDTH'(step);
   end

   // ==========================================================
   // State
   // Load beats increment so a write lands exactly as written
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= load_value;
      end else if (inc) begin
         count_reg <= count_next;
      end
   end

endmodule

`default_nettype wire

// ---- event_source.sv ----
/*
 * Far-side model: queue and bus logic presenting event conditions and latency weights.
 * Assumes the bench picks the mode; outputs change only just after mclk edges.
 */
`timescale 1ns/10ps
`default_nettype none

module event_source (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [1:0] mode,
   output logic [191:0] event_cond,
   output logic [7:0] latency_weight
);
   // ==========================================
   // Pattern generator
   logic [31:0] lfsr_reg;

   // Seed must be non-zero or the pattern locks up
   always_ff @(posedge mclk) begin
      if (sys_rst) lfsr_reg <= 32'h0000_0001;
      else lfsr_reg <= {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
   end

   always_comb begin
      case (mode)
         2'h0: event_cond = '0;
         2'h1: event_cond = '1;
         default: event_cond = {lfsr_reg, ~lfsr_reg, lfsr_reg, ~lfsr_reg, lfsr_reg, ~lfsr_reg};
      endcase
      latency_weight = (mode == 2'h1) ? 8'hFF : ((mode == 2'h0) ? 8'h00 : lfsr_reg[7:0]);
   end
endmodule
`default_nettype wire

// ---- test_l3_bus_event_counters.sv ----
/*
 * Self-checking bench for the event counter bank with a cycle model of all eight registers.
 * Assumes the design answers every request exactly one cycle after it is taken.
 */
`timescale 1ns/10ps
`default_nettype none

module test_l3_bus_event_counters;
   import l3_event_pkg::*;
   logic mclk, sys_rst, msr_rd_req, msr_wr_req, pmc_rd_req;
   logic [31:0] msr_addr;
   logic [63:0] msr_wdata;
   logic [7:0] pmc_index;
   logic [1:0] src_mode;
   wire logic [191:0] event_cond;
   wire logic [7:0] latency_weight;
   wire logic [63:0] msr_rdata_reg;
   wire logic [31:0] pmc_rdata_lo_reg, pmc_rdata_hi_reg;
   wire logic msr_ack_reg, msr_fault_reg, pmc_ack_reg, pmc_fault_reg;
   int mismatches, n_compared;
   logic [63:0] mdl [8];
   logic [63:0] exp_rd;
   logic [31:0] exp_pmc;
   logic exp_flt, exp_pflt, map_a;
   logic [2:0] slot;

   l3_bus_event_counters uut (.mclk(mclk), .sys_rst(sys_rst), .msr_rd_req(msr_rd_req),
      .msr_wr_req(msr_wr_req), .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_rdata_reg(msr_rdata_reg),
      .msr_ack_reg(msr_ack_reg), .msr_fault_reg(msr_fault_reg), .pmc_rd_req(pmc_rd_req),
      .pmc_index(pmc_index), .pmc_rdata_lo_reg(pmc_rdata_lo_reg), .pmc_rdata_hi_reg(pmc_rdata_hi_reg),
      .pmc_ack_reg(pmc_ack_reg), .pmc_fault_reg(pmc_fault_reg), .event_cond(event_cond),
      .latency_weight(latency_weight));
   event_source src (.mclk(mclk), .sys_rst(sys_rst), .mode(src_mode), .event_cond(event_cond),
      .latency_weight(latency_weight));

   // ==========================================
   // Reference model, reads see values before the edge's update
   always @(posedge mclk) begin
      map_a = (msr_addr >= ADDR_INBOUND_BUS_QUEUE_EVENT0) && (msr_addr <= ADDR_QUEUE_LATENCY_ACCUMULATOR);
      slot = 3'(msr_addr - ADDR_INBOUND_BUS_QUEUE_EVENT0);
      if (msr_rd_req || msr_wr_req) exp_flt = !map_a;
      if (msr_rd_req) exp_rd = map_a ? mdl[slot] : 64'h0;
      if (pmc_rd_req) begin
         exp_pflt = (pmc_index < PMC_INDEX_FIRST) || (pmc_index > PMC_INDEX_LAST);
         exp_pmc = exp_pflt ? 32'h0 : mdl[3'(pmc_index - PMC_INDEX_FIRST)][31:0];
      end
      if (sys_rst) begin
         foreach (mdl[k]) mdl[k] = 64'h0;
      end else begin
         for (int k = 0; k < 6; k++) begin
            if (mdl[k][63:32] != 0 && (mdl[k][63:32] & event_cond[k*32 +: 32]) != 0) mdl[k][31:0] += 1;
         end
         if (mdl[6][LATENCY_ENABLE_BIT]) mdl[7] += 64'(latency_weight);
         if (msr_wr_req && map_a) mdl[slot] = msr_wdata;
      end
   end

   // ==========================================
   // Compare and bus tasks
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp, input logic got);
      chk(what, {63'h0, exp}, {63'h0, got});
   endtask

   task automatic msr_xfer(input logic wr, input logic [31:0] a, input logic [63:0] d);
      msr_wr_req = wr;
      msr_rd_req = !wr;
      msr_addr = a;
      msr_wdata = d;
      @(posedge mclk);
      #1;
      msr_wr_req = 1'b0;
      msr_rd_req = 1'b0;
      chk_flag("msr ack", 1'b1, msr_ack_reg);
      chk_flag("msr fault", exp_flt, msr_fault_reg);
      if (!wr) chk("msr data", exp_rd, msr_rdata_reg);
      @(posedge mclk);
      #1;
   endtask

   task automatic pmc_rd(input logic [7:0] idx);
      pmc_rd_req = 1'b1;
      pmc_index = idx;
      @(posedge mclk);
      #1;
      pmc_rd_req = 1'b0;
      chk_flag("pmc ack", 1'b1, pmc_ack_reg);
      chk_flag("pmc fault", exp_pflt, pmc_fault_reg);
      chk("pmc low", {32'h0, exp_pmc}, {32'h0, pmc_rdata_lo_reg});
      chk("pmc high", 64'h0, {32'h0, pmc_rdata_hi_reg});
      @(posedge mclk);
      #1;
   endtask

   task automatic read_all;
      for (int k = 0; k < 8; k++) msr_xfer(1'b0, ADDR_INBOUND_BUS_QUEUE_EVENT0 + k, 64'h0);
      for (int i = 17; i < 27; i++) pmc_rd(8'(i));
   endtask

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ==========================================
   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      end_of_test();
   end

   // ==========================================
   // Main sequence
   initial begin
      mismatches = 0;
      n_compared = 0;
      {sys_rst, msr_rd_req, msr_wr_req, pmc_rd_req} = 4'h8;
      msr_addr = 32'h0;
      msr_wdata = 64'h0;
      pmc_index = 8'h0;
      src_mode = 2'h0;
      void'($urandom(60));
      repeat (3) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      @(posedge mclk);
      #1;
      read_all();
      $display("test reset_values done");
      src_mode = 2'h1;
      repeat (20) @(posedge mclk);
      #1;
      read_all();
      msr_xfer(1'b1, ADDR_INBOUND_SNOOP_QUEUE_EVENT0, {32'h0, $urandom()});
      msr_xfer(1'b0, ADDR_INBOUND_SNOOP_QUEUE_EVENT0, 64'h0);
      $display("test idle_until_enabled done");
      src_mode = 2'h2;
      for (int k = 0; k < 6; k++) msr_xfer(1'b1, ADDR_INBOUND_BUS_QUEUE_EVENT0 + k, {$urandom(), $urandom()});
      repeat (50) @(posedge mclk);
      #1;
      read_all();
      $display("test qualified_counting done");
      src_mode = 2'h1;
      msr_xfer(1'b1, ADDR_EXTERNAL_BUS_READY_EVENT1, 64'hFFFF_FFFF_FFFF_FFFD);
      repeat (4) @(posedge mclk);
      #1;
      read_all();
      $display("test counter_wrap done");
      src_mode = 2'h2;
      msr_xfer(1'b1, ADDR_QUEUE_LATENCY_ACCUMULATOR, 64'h0000_0000_FFFF_FF00);
      msr_xfer(1'b1, ADDR_QUEUE_LATENCY_CONTROL, {$urandom(), $urandom()} | 64'h0000_0000_0400_0000);
      repeat (30) @(posedge mclk);
      #1;
      msr_xfer(1'b0, ADDR_QUEUE_LATENCY_ACCUMULATOR, 64'h0);
      msr_xfer(1'b1, ADDR_QUEUE_LATENCY_CONTROL, 64'h0);
      repeat (10) @(posedge mclk);
      #1;
      read_all();
      $display("test latency_accumulate done");
      msr_xfer(1'b1, 32'h0001_07CB, {$urandom(), $urandom()});
      msr_xfer(1'b1, 32'h0001_07D4, {$urandom(), $urandom()});
      msr_xfer(1'b0, 32'h0001_07D4, 64'h0);
      read_all();
      $display("test unmapped_access done");
      end_of_test();
   end
endmodule
`default_nettype wire
